// *** bench/opas_mem_model.sv ***
// Purpose: Program and data memory as seen from the core
// Assumes: Requests are one-cycle pulses, address held as a level
// Notes: Counts and vets requests only, stores no contents
`timescale 1ns/10ps
`default_nettype none
module opas_mem_model
   import opas_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Requests from the core
   input  wire opas_dmem_t  dmem_q,
   input  wire logic        dmem_req_q,
   input  wire logic [14:0] pmem_addr_q,
   input  wire logic        pmem_req_q,
   // Tallies for the bench
   output logic [15:0]      d_cnt_q,
   output logic [15:0]      p_cnt_q,
   output logic [15:0]      bad_q
);
   logic odd_wide;
   logic bad_bank;
   logic hi_prog;
   // A word at an odd nibble would straddle two words
   assign odd_wide = dmem_req_q & dmem_q.wide & dmem_q.addr[0];
   assign bad_bank = dmem_req_q & (dmem_q.bank > 4'h3) & (dmem_q.bank != BANK_15);
   assign hi_prog  = pmem_req_q & (pmem_addr_q > 15'h7F7F);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         d_cnt_q <= 16'h0000;
         p_cnt_q <= 16'h0000;
         bad_q   <= 16'h0000;
      end else begin
         d_cnt_q <= d_cnt_q + 16'(dmem_req_q);
         p_cnt_q <= p_cnt_q + 16'(pmem_req_q);
         bad_q   <= bad_q + 16'(odd_wide) + 16'(bad_bank) + 16'(hi_prog);
      end
   end
endmodule
`default_nettype wire

// *** bench/test_operand_addressing_skip_timing.sv ***
// Purpose: Random self-checking bench for operand addressing and skip timing
// Assumes: APB slave answers after one wait state
// Notes: Expectations come from bench functions and inline bench code
`timescale 1ns/10ps
`default_nettype none
module test_operand_addressing_skip_timing
   import opas_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   opas_dmem_t  dmem_q;
   logic        dmem_req_q;
   logic [14:0] pmem_addr_q;
   logic        pmem_req_q;
   logic        mcyc_tick_q;
   logic [15:0] d_cnt;
   logic [15:0] p_cnt;
   logic [15:0] bad;
   int          n_mismatch = 0;
   int          checked    = 0;

   always #20 sys_clk = ~sys_clk;

   opas_core #(.TICK_W(7)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dmem_q(dmem_q), .dmem_req_q(dmem_req_q), .pmem_addr_q(pmem_addr_q),
      .pmem_req_q(pmem_req_q), .mcyc_tick_q(mcyc_tick_q));
   opas_mem_model i_mem (
      .sys_clk(sys_clk), .rst(rst), .dmem_q(dmem_q), .dmem_req_q(dmem_req_q),
      .pmem_addr_q(pmem_addr_q), .pmem_req_q(pmem_req_q), .d_cnt_q(d_cnt),
      .p_cnt_q(p_cnt), .bad_q(bad));

   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask

   // Values read right after an edge are those sampled at it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         n_mismatch++;
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
   endtask

   // First gaps after a divider change may be partial, so the third is measured
   task automatic tick_gap(input int k, input int exp);
      int n;
      wr(OFS_CTRL, 32'(k) << CT_CK);
      repeat (3) begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (mcyc_tick_q !== 1'b1 && n < 100);
      end
      if (n >= 100) begin
         n_mismatch++;
         final_report();
      end
      cmp("machine cycle", 32'(exp), 32'(n));
   endtask

   function automatic logic [4:0] dres_exp(input logic [2:0] c, input logic be,
                                           input logic [3:0] bs, input logic [11:0] a,
                                           input logic w);
      logic bad_bs;
      bad_bs = be && !(bs <= 4'h3 || bs == BANK_15);
      case (c)
         3'h0: return {(w & a[0]) | bad_bs, be ? bs : (a[7] ? BANK_15 : BANK_0)};
         3'h4, 3'h5: return {1'b0, BANK_0};
         3'h6: return {!((a >= FB_LO && a <= FB_HI) || a >= FF_LO), BANK_15};
         3'h7: return {a < PM_LO, BANK_15};
         default: return {bad_bs, be ? bs : BANK_0};
      endcase
   endfunction

   function automatic logic [15:0] bres_exp(input int k, input logic [14:0] pc,
                                            input logic [15:0] t);
      logic [15:0] d;
      d = t - {1'b0, pc};
      case (k)
         0: return {!(d >= RN_LO || (d >= RP_LO && d <= RP_HI)), t[14:0]};
         1: return {t[15:12] != 4'h0 || ((pc[14:12] == CB_BLKA || pc[14:12] == CB_BLKB)
                    && t[11:0] > CB_TOP), pc[14:12], t[11:0]};
         2: return {t > FA_HI, t[14:0]};
         3: return {t < TA_LO || t > TA_HI, t[14:1], 1'b0};
         4: return {t > AB_HI, t[14:0]};
         default: return {t > A1_HI, t[14:0]};
      endcase
   endfunction

   initial begin
      int          i;
      int          k;
      logic [31:0] r;
      logic [31:0] v;
      logic        e;
      logic [2:0]  c;
      logic        be;
      logic [3:0]  bs;
      logic [11:0] a;
      logic        w;
      logic [1:0]  b;
      logic [4:0]  ed;
      logic [15:0] ep;
      logic [15:0] cnt;
      logic [14:0] pc;
      logic [15:0] t;
      logic [7:0]  hl;
      logic [7:0]  de;
      logic [7:0]  ea;
      void'($urandom(32'hcc54b950));
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rd(OFS_CTRL, r);
      cmp("ctrl reset", CTRL_RST, r);
      v = $urandom();
      wr(OFS_CTRL, v);
      rd(OFS_CTRL, r);
      cmp("ctrl readback", v & 32'h0000_37F1, r);
      apb(1'b0, 8'h20, 32'h0000_0000, r, e);
      cmp("unmapped error", 32'h0000_0001, 32'(e));
      for (i = 0; i < 16; i++) begin
         v = $urandom_range(0, 255);
         wr(OFS_REGA, (32'(i) << RA_SEL) | v);
         rd(OFS_REGA, r);
         if (i == 10) de = v[7:0];
         if (i == 11) hl = v[7:0];
         cmp("register", (32'(i) << RA_SEL) | (i[3] ? v : v & 32'h0000_000F), r);
      end
      for (i = 0; i < 80; i++) begin
         c  = 3'($urandom_range(0, 7));
         be = 1'($urandom);
         bs = 4'($urandom);
         a  = (c > 3'h5) ? {4'hF, 8'($urandom)} : 12'($urandom_range(0, 255));
         w  = (c == 3'h0) ? 1'($urandom) : 1'b0;
         b  = 2'($urandom);
         wr(OFS_CTRL, 32'(be) | (32'(bs) << CT_BS));
         cnt = d_cnt;
         wr(OFS_OPND, 32'(c) | (32'(w) << OP_WIDE) | (32'(b) << OP_BIT) | (32'(a) << OP_ADR));
         rd(OFS_DRES, r);
         ed = dres_exp(c, be, bs, a, w);
         // Pairs hold what the register loop left there, L moves with HL+/HL-
         ea = (c == 3'h0 || c > 3'h5) ? a[7:0] :
              (c > 3'h3) ? {de[7:4], c[0] ? hl[3:0] : de[3:0]} : hl;
         cmp("operand error", 32'(ed[4]), 32'(r[RS_ERR]));
         cmp("request count", 32'(cnt + 16'(!ed[4])), 32'(d_cnt));
         if (!ed[4]) begin
            cmp("data bank", 32'(ed[3:0]), 32'(r[3:0]));
            cmp("memory bank", 32'(ed[3:0]), 32'(dmem_q.bank));
            cmp("bit select", 32'(b), 32'(r[13:12]));
            cmp("data addr", 32'(ea), 32'(r[11:4]));
            cmp("memory addr", 32'(ea), 32'(dmem_q.addr));
            cmp("memory bits", 32'(b), 32'(dmem_q.bitsel));
            cmp("wide flag", 32'(w), 32'(r[14]));
         end
         if (c == 3'h2 || c == 3'h3) begin
            hl[3:0] = (c == 3'h2) ? hl[3:0] + 4'h1 : hl[3:0] - 4'h1;
            cmp("skip flag", 32'(hl[3:0] == (c == 3'h2 ? 4'h0 : 4'hF)), 32'(r[15]));
         end
      end
      for (i = 0; i < 80; i++) begin
         k  = $urandom_range(0, 5);
         pc = 15'($urandom);
         t  = (k == 0) ? {1'b0, pc} : (k == 1) ? 16'h0F7F : (k == 2) ? FA_HI :
              (k == 3) ? TA_LO : (k == 4) ? AB_HI : A1_HI;
         t  = t + 16'($urandom_range(0, 36)) - 16'h0012;
         if ($urandom_range(0, 3) == 0) t = 16'($urandom);
         wr(OFS_PC, 32'(pc));
         cnt = p_cnt;
         wr(OFS_TGT, (32'(k) << TG_KND) | 32'(t));
         rd(OFS_BRES, r);
         ep = bres_exp(k, pc, t);
         cmp("target error", 32'(ep[15]), 32'(r[RS_ERR]));
         cmp("fetch count", 32'(cnt + 16'(!ep[15])), 32'(p_cnt));
         if (!ep[15]) cmp("target", 32'(ep[14:0]), 32'(pmem_addr_q));
      end
      for (i = 0; i < 16; i++) begin
         if (i[2:1] == 2'h3) continue;
         v = 32'($urandom_range(0, 15)) | (32'(i) << SK_TKN);
         wr(OFS_SKIP, v);
         rd(OFS_SKIP, r);
         k = v[3:0] + (i[0] ? (i[3] ? 1 : (i[2:1] == 2'h2 ? 2 : 1)) : 0);
         cmp("skip total", 32'(k) << SK_TOT | v[7:0], r & 32'h0000_1FFF);
      end
      tick_gap(0, 64);
      tick_gap(1, 32);
      tick_gap(2, 16);
      tick_gap(3, 4);
      cmp("illegal requests", 32'h0000_0000, 32'(bad));
      final_report();
   end
endmodule
`default_nettype wire

// *** common/opas_pkg.sv ***
// Purpose: Shared constants and types for operand addressing and skip timing
// Assumes: APB register access, one clock, 32-bit data
// Notes: Offsets are byte addresses of aligned words
package opas_pkg;
   // Register offsets
   localparam logic [7:0]  OFS_CTRL = 8'h00;
   localparam logic [7:0]  OFS_REGA = 8'h04;
   localparam logic [7:0]  OFS_OPND = 8'h08;
   localparam logic [7:0]  OFS_DRES = 8'h0C;
   localparam logic [7:0]  OFS_PC   = 8'h10;
   localparam logic [7:0]  OFS_TGT  = 8'h14;
   localparam logic [7:0]  OFS_BRES = 8'h18;
   localparam logic [7:0]  OFS_SKIP = 8'h1C;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // Field positions
   localparam int CT_BE   = 0;
   localparam int CT_BS   = 4;
   localparam int CT_RE   = 8;
   localparam int CT_RS   = 9;
   localparam int CT_CK   = 12;
   localparam int RA_SEL  = 12;
   localparam int RA_PAIR = 15;
   localparam int OP_CLS  = 0;
   localparam int OP_WIDE = 3;
   localparam int OP_BIT  = 4;
   localparam int OP_ADR  = 8;
   localparam int TG_KND  = 16;
   localparam int SK_TKN  = 4;
   localparam int SK_LEN  = 5;
   localparam int SK_TBL  = 7;
   localparam int SK_TOT  = 8;
   localparam int RS_ERR  = 16;
   // Banks and register indices
   localparam logic [3:0]  BANK_0  = 4'h0;
   localparam logic [3:0]  BANK_15 = 4'hF;
   localparam logic [3:0]  IX_D    = 4'h4;
   localparam logic [3:0]  IX_E    = 4'h5;
   localparam logic [3:0]  IX_H    = 4'h6;
   localparam logic [3:0]  IX_L    = 4'h7;
   // Operand ranges
   localparam logic [11:0] FB_LO   = 12'hFB0;
   localparam logic [11:0] FB_HI   = 12'hFBF;
   localparam logic [11:0] FF_LO   = 12'hFF0;
   localparam logic [11:0] FF_HI   = 12'hFFF;
   localparam logic [11:0] PM_LO   = 12'hFC0;
   localparam logic [15:0] RN_LO   = 16'hFFF1;
   localparam logic [15:0] RN_HI   = 16'hFFFF;
   localparam logic [15:0] RP_LO   = 16'h0002;
   localparam logic [15:0] RP_HI   = 16'h0010;
   localparam logic [11:0] CB_TOP  = 12'hF7F;
   localparam logic [2:0]  CB_BLKA = 3'h5;
   localparam logic [2:0]  CB_BLKB = 3'h7;
   localparam logic [15:0] FA_HI   = 16'h07FF;
   localparam logic [15:0] TA_LO   = 16'h0020;
   localparam logic [15:0] TA_HI   = 16'h007F;
   localparam logic [15:0] AB_HI   = 16'h3F7F;
   localparam logic [15:0] A1_HI   = 16'h7F7F;
   localparam logic [15:0] ZERO16  = 16'h0000;
   // Skip cycle additions
   localparam logic [1:0]  LEN_3B  = 2'h2;
   localparam logic [4:0]  S_NONE  = 5'h00;
   localparam logic [4:0]  S_SHORT = 5'h01;
   localparam logic [4:0]  S_LONG  = 5'h02;
   // System clocks per machine cycle, by clock select
   localparam logic [6:0]  CK_DIV [4] = '{7'h40, 7'h20, 7'h10, 7'h04};
   typedef enum logic [2:0] {
      CLS_MEM, CLS_HL, CLS_HLINC, CLS_HLDEC, CLS_DE, CLS_DL, CLS_FMEM, CLS_PMEM
   } opas_cls_t;
   typedef enum logic [2:0] {
      BK_REL, BK_CADDR, BK_FADDR, BK_TADDR, BK_ABS, BK_ABS1
   } opas_bk_t;
   typedef struct packed {
      logic [3:0] bank;
      logic [7:0] addr;
      logic [1:0] bitsel;
      logic       wide;
   } opas_dmem_t;
endpackage

// *** verilog/opas_core.sv ***
// Purpose: Operand addressing, bank selection and skip timing
// Assumes: APB master, inputs synchronous to sys_clk
// Notes: Illegal operands are flagged and loaded into dmem_q but never requested
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module opas_core
   import opas_pkg::*;
#(
   parameter int TICK_W = 7
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Data memory side
   output opas_dmem_t       dmem_q,
   output logic             dmem_req_q,
   // Program memory side
   output logic [14:0]      pmem_addr_q,
   output logic             pmem_req_q,
   // Machine cycle
   output logic             mcyc_tick_q
);
   if (TICK_W < 7) begin : g_chk
      $error("TICK_W must hold the largest clock divisor");
   end

   logic [31:0]     ctrl_q;
   logic [3:0]      rf_q [16];
   logic [3:0]      rf_d [16];
   logic [3:0]      ra_q;
   logic            rp_q;
   logic [31:0]     dres_q;
   logic [14:0]     pc_q;
   logic [31:0]     bres_q;
   logic [31:0]     skip_q;
   logic [TICK_W-1:0] cnt_q;

   // Bus decode
   logic acc_first, done, wr;
   logic s_ctrl, s_rega, s_opnd, s_dres, s_pc, s_tgt, s_bres, s_skip, mapped;
   assign acc_first = psel & penable & ~pready;
   assign done      = psel & penable & pready;
   assign wr        = done & pwrite;
   assign s_ctrl    = paddr == OFS_CTRL;
   assign s_rega    = paddr == OFS_REGA;
   assign s_opnd    = paddr == OFS_OPND;
   assign s_dres    = paddr == OFS_DRES;
   assign s_pc      = paddr == OFS_PC;
   assign s_tgt     = paddr == OFS_TGT;
   assign s_bres    = paddr == OFS_BRES;
   assign s_skip    = paddr == OFS_SKIP;
   assign mapped    = s_ctrl | s_rega | s_opnd | s_dres | s_pc | s_tgt | s_bres | s_skip;

   // Register file view, pair mode reads high nibble first
   logic [3:0] ra_idx_hi, ra_idx_lo;
   logic [7:0] ra_val;
   assign ra_idx_hi = rp_q ? {ra_q[2], ra_q[1:0], 1'b0} : {1'b0, ra_q[2:0]};
   assign ra_idx_lo = {ra_q[2], ra_q[1:0], 1'b1};
   assign ra_val    = rp_q ? {rf_q[ra_idx_hi], rf_q[ra_idx_lo]} : {4'h0, rf_q[ra_idx_hi]};

   logic [31:0] rdata;
   assign rdata = s_ctrl ? ctrl_q :
                  s_rega ? {16'h0000, rp_q, ra_q[2:0], 4'h0, ra_val} :
                  s_dres ? dres_q :
                  s_pc   ? {17'h0_0000, pc_q} :
                  s_bres ? bres_q :
                  s_skip ? skip_q : 32'h0000_0000;

   // Control fields
   logic       be;
   logic [3:0] bs;
   logic [1:0] ck_sel;
   assign be     = ctrl_q[CT_BE];
   assign bs     = ctrl_q[CT_BS +: 4];
   assign ck_sel = ctrl_q[CT_CK +: 2];

   // Data operand decode
   opas_cls_t  cls;
   logic [11:0] op_adr;
   logic       is_hl, is_dptr, is_fix, bs_ok;
   logic [3:0] eff_bank;
   logic [7:0] eff_addr;
   assign cls     = opas_cls_t'(pwdata[OP_CLS +: 3]);
   assign op_adr  = pwdata[OP_ADR +: 12];
   assign is_hl   = (cls == CLS_HL) | (cls == CLS_HLINC) | (cls == CLS_HLDEC);
   assign is_dptr = (cls == CLS_DE) | (cls == CLS_DL);
   assign is_fix  = (cls == CLS_FMEM) | (cls == CLS_PMEM);
   assign bs_ok   = (bs[3:2] == 2'h0) | (bs == BANK_15);
   // Bank settles before the access edge
   assign eff_bank = is_dptr ? BANK_0 :
                     is_fix  ? BANK_15 :
                     be      ? bs :
                     (cls == CLS_MEM && op_adr[7]) ? BANK_15 : BANK_0;
   assign eff_addr = is_hl ? {rf_q[IX_H], rf_q[IX_L]} :
                     (cls == CLS_DE) ? {rf_q[IX_D], rf_q[IX_E]} :
                     (cls == CLS_DL) ? {rf_q[IX_D], rf_q[IX_L]} : op_adr[7:0];

   logic fb_hit, ff_hit, pm_hit, fix_err, op_err;
   opas_rng #(.W(12)) u_fb (.val(op_adr), .lo(FB_LO), .hi(FB_HI), .hit(fb_hit));
   opas_rng #(.W(12)) u_ff (.val(op_adr), .lo(FF_LO), .hi(FF_HI), .hit(ff_hit));
   opas_rng #(.W(12)) u_pm (.val(op_adr), .lo(PM_LO), .hi(FF_HI), .hit(pm_hit));
   assign fix_err = ((cls == CLS_FMEM) & ~(fb_hit | ff_hit)) |
                    ((cls == CLS_PMEM) & ~pm_hit);
   // Odd address for an 8-bit access, bad bank select in use, or fix_err
   assign op_err  = (pwdata[OP_WIDE] & eff_addr[0]) |
                    (be & ~is_dptr & ~is_fix & ~bs_ok) | fix_err;

   // Post-modify of L and the resulting skip condition
   logic [3:0] l_now, l_next;
   logic       l_mod, skip_cond;
   assign l_now     = rf_q[IX_L];
   assign l_mod     = cls == CLS_HLINC || cls == CLS_HLDEC;
   assign l_next    = (cls == CLS_HLINC) ? l_now + 4'h1 : l_now - 4'h1;
   assign skip_cond = (cls == CLS_HLINC) ? (l_next == 4'h0) : (l_next == 4'hF);

   logic wr_rega, wr_opnd;
   assign wr_rega = wr & s_rega;
   assign wr_opnd = wr & s_opnd;

   always_comb begin
      rf_d = rf_q;
      if (wr_rega) begin
         if (pwdata[RA_PAIR]) begin
            // Pair select: bit 2 picks the primed set
            rf_d[{pwdata[RA_SEL + 2], pwdata[RA_SEL +: 2], 1'b0}] = pwdata[7:4];
            rf_d[{pwdata[RA_SEL + 2], pwdata[RA_SEL +: 2], 1'b1}] = pwdata[3:0];
         end else begin
            rf_d[{1'b0, pwdata[RA_SEL +: 3]}] = pwdata[3:0];
         end
      end
      if (wr_opnd && l_mod) begin
         rf_d[IX_L] = l_next;
      end
   end

   // Program target decode
   opas_bk_t    knd;
   logic [15:0] tgt, diff;
   logic        rn_hit, rp_hit, fa_hit, ta_hit, ab_hit, a1_hit, cb_err;
   logic [14:0] br_res;
   logic        br_err;
   assign knd  = opas_bk_t'(pwdata[TG_KND +: 3]);
   assign tgt  = pwdata[15:0];
   assign diff = tgt - {1'b0, pc_q};
   opas_rng #(.W(16)) u_rn (.val(diff), .lo(RN_LO), .hi(RN_HI), .hit(rn_hit));
   opas_rng #(.W(16)) u_rp (.val(diff), .lo(RP_LO), .hi(RP_HI), .hit(rp_hit));
   opas_rng #(.W(16)) u_fa (.val(tgt), .lo(ZERO16), .hi(FA_HI), .hit(fa_hit));
   opas_rng #(.W(16)) u_ta (.val({tgt[15:1], 1'b0}), .lo(TA_LO), .hi(TA_HI), .hit(ta_hit));
   opas_rng #(.W(16)) u_ab (.val(tgt), .lo(ZERO16), .hi(AB_HI), .hit(ab_hit));
   opas_rng #(.W(16)) u_a1 (.val(tgt), .lo(ZERO16), .hi(A1_HI), .hit(a1_hit));
   // Two blocks stop short of their top 128 bytes
   assign cb_err = (pc_q[14:12] == CB_BLKA || pc_q[14:12] == CB_BLKB)
                   && (tgt[11:0] > CB_TOP);
   assign br_res = (knd == BK_CADDR) ? {pc_q[14:12], tgt[11:0]} :
                   (knd == BK_FADDR) ? {4'h0, tgt[10:0]} :
                   (knd == BK_TADDR) ? {8'h00, tgt[6:1], 1'b0} : tgt[14:0];
   assign br_err = (knd == BK_REL)   ? ~(rn_hit | rp_hit) :
                   (knd == BK_CADDR) ? (cb_err | (tgt[15:12] != 4'h0)) :
                   (knd == BK_FADDR) ? ~fa_hit :
                   (knd == BK_TADDR) ? ~ta_hit :
                   (knd == BK_ABS)   ? ~ab_hit :
                   (knd == BK_ABS1)  ? ~a1_hit : 1'b1;

   // Skip cycle count
   logic [4:0] s_add, skip_base, skip_tot;
   assign s_add     = ~pwdata[SK_TKN] ? S_NONE :
                      pwdata[SK_TBL] ? S_SHORT :
                      (pwdata[SK_LEN +: 2] == LEN_3B) ? S_LONG : S_SHORT;
   assign skip_base = {1'b0, pwdata[3:0]};
   assign skip_tot  = skip_base + s_add;

   // Machine cycle divider
   logic [TICK_W-1:0] div_m1;
   logic              tick_last;
   assign div_m1    = TICK_W'(CK_DIV[ck_sel] - 7'h01);
   assign tick_last = cnt_q >= div_m1;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc_first;
         pslverr <= acc_first & ~mapped;
         if (acc_first) begin
            prdata <= rdata;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         pc_q   <= 15'h0000;
         ra_q   <= 4'h0;
         rp_q   <= 1'b0;
      end else if (wr) begin
         if (s_ctrl) begin
            ctrl_q <= {18'h0_0000, pwdata[CT_CK +: 2], 1'b0, pwdata[CT_RS +: 2],
                       pwdata[CT_RE], pwdata[CT_BS +: 4], 3'h0, pwdata[CT_BE]};
         end
         if (s_pc) begin
            pc_q <= pwdata[14:0];
         end
         if (s_rega) begin
            ra_q <= {1'b0, pwdata[RA_SEL +: 3]};
            rp_q <= pwdata[RA_PAIR];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            rf_q[i] <= 4'h0;
         end
      end else begin
         rf_q <= rf_d;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dres_q     <= 32'h0000_0000;
         dmem_q     <= '0;
         dmem_req_q <= 1'b0;
      end else begin
         dmem_req_q <= wr_opnd & ~op_err;
         if (wr_opnd) begin
            dres_q <= {15'h0000, op_err, l_mod & skip_cond, pwdata[OP_WIDE],
                       pwdata[OP_BIT +: 2], eff_addr, eff_bank};
            dmem_q <= '{bank: eff_bank, addr: eff_addr,
                        bitsel: pwdata[OP_BIT +: 2], wide: pwdata[OP_WIDE]};
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bres_q      <= 32'h0000_0000;
         pmem_addr_q <= 15'h0000;
         pmem_req_q  <= 1'b0;
         skip_q      <= 32'h0000_0000;
      end else begin
         pmem_req_q <= wr & s_tgt & ~br_err;
         if (wr & s_tgt) begin
            bres_q      <= {15'h0000, br_err, 1'b0, br_res};
            pmem_addr_q <= br_res;
         end
         if (wr & s_skip) begin
            skip_q <= {19'h0_0000, skip_tot, pwdata[7:0]};
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q       <= '0;
         mcyc_tick_q <= 1'b0;
      end else begin
         cnt_q       <= tick_last ? '0 : cnt_q + 1'b1;
         mcyc_tick_q <= tick_last;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   even_wide_a: assert property (dmem_req_q && dmem_q.wide |-> !dmem_q.addr[0])
      else $error("odd address on 8-bit access");
   rpa_bank_a: assert property (wr_opnd && is_dptr |=> dmem_q.bank == BANK_0)
      else $error("DE or DL access left bank 0");
   fix_bank_a: assert property (wr_opnd && is_fix |=> dmem_q.bank == BANK_15)
      else $error("bit operand left bank 15");
   mem_bank_a: assert property (wr_opnd && cls == CLS_MEM && !be |=>
      dmem_q.bank == ($past(op_adr[7]) ? BANK_15 : BANK_0))
      else $error("wrong bank with bank enable off");
   hl_inc_a: assert property (wr_opnd && cls == CLS_HLINC |=>
      l_now == $past(l_now) + 4'h1)
      else $error("L not incremented");
   hl_dec_a: assert property (wr_opnd && cls == CLS_HLDEC |=>
      l_now == $past(l_now) - 4'h1)
      else $error("L not decremented");
   no_skip_a: assert property (wr && s_skip && !pwdata[SK_TKN] |=>
      skip_q[SK_TOT +: 5] == $past(skip_base))
      else $error("cycles added without a skip");
   long_skip_a: assert property (wr && s_skip && pwdata[SK_TKN] && !pwdata[SK_TBL]
      && pwdata[SK_LEN +: 2] == LEN_3B |=> skip_q[SK_TOT +: 5] == $past(skip_base) + S_LONG)
      else $error("3-byte skip not two cycles");
   tick_gap_a: assert property (mcyc_tick_q |=> !mcyc_tick_q [*3])
      else $error("machine cycle shorter than divisor");
   blk_keep_a: assert property (wr && s_tgt && knd == BK_CADDR && !br_err |=>
      pmem_req_q && pmem_addr_q[14:12] == $past(pc_q[14:12]))
      else $error("in-block target left its block");
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("ready held over two cycles");
endmodule
`default_nettype wire

// *** verilog/opas_rng.sv ***
// Purpose: Inclusive range compare
// Assumes: Unsigned operands
// Notes: Pure combinational
`timescale 1ns/10ps
`default_nettype none
module opas_rng #(
   parameter int W = 16
) (
   // Operand and bounds
   input  wire logic [W-1:0] val,
   input  wire logic [W-1:0] lo,
   input  wire logic [W-1:0] hi,
   // Result
   output logic              hit
);
   assign hit = (val >= lo) && (val <= hi);
endmodule
`default_nettype wire
